/* File: pkg/ief_pkg.sv */
// Constants shared by the integrity error flag logic.
package ief_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned ADDR_W         = 7;
  localparam logic [6:0]  ADDR_STATUS    = 7'h06;
  localparam logic [6:0]  ADDR_MASK      = 7'h07;
  localparam logic [6:0]  ADDR_LAST_DEF  = 7'h3f;
  localparam logic [15:0] MASK_RESET     = 16'h0040;
  localparam logic [15:0] MASK_WRITABLE  = 16'h1fff;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_IMPL    = 16'h001f;

  // ==========================================================================
  // Flag positions, shared by status and enable mask
  // ==========================================================================
  localparam int unsigned BIT_ROM_SUM    = 0;
  localparam int unsigned BIT_MAP_SUM    = 1;
  localparam int unsigned BIT_LINK_SUM   = 2;
  localparam int unsigned BIT_BAD_WRITE  = 3;
  localparam int unsigned BIT_BAD_READ   = 4;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned MAP_CHECK_US      = 8;
  localparam int unsigned MAP_CHECK_CYCLES  = (MAP_CHECK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W           = 16;

  typedef enum logic [1:0] {
    IEF_ROM_RUN   = 2'b00,
    IEF_ROM_CHECK = 2'b01,
    IEF_ROM_DONE  = 2'b10
  } ief_rom_state_type;

endpackage : ief_pkg

/* File: logic/ief_flags.sv */
// Sticky integrity error flags with their enable mask and checksum checkers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Read of an invalid address sets the invalid-read flag; reset zero, write one clears.
// - Write to an invalid address sets the invalid-write flag; sticky, write one clears.
// - A failed link checksum sets flag bit 2.
// - While enabled, map checksum is recomputed periodically and compared with expected.
// - Periodic map checksum mismatch without host write sets the map-integrity flag.
// - After power-up ROM checksum is computed; mismatch sets flag bit 0.
// - Enable mask register at 0x07 resets to 0x0040; bits 0 to 4 each enable their flag, the other bits enable nothing.
module ief_flags
  import ief_pkg::*;
#(
  parameter int unsigned MAP_WORDS    = 16,
  parameter int unsigned ROM_WORDS    = 64,
  parameter int unsigned CHECK_CYCLES = MAP_CHECK_CYCLES,
  parameter logic [6:0]  ADDR_LAST    = ADDR_LAST_DEF,
  parameter logic [15:0] ROM_SUM      = 16'h0000
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [6:0]             reg_addr_i,
  input  wire logic [15:0]            reg_wdata_i,
  input  wire logic                   link_sum_fail_i,
  input  wire logic [MAP_WORDS*16-1:0] map_data_i,
  input  wire logic [15:0]            rom_data_i,
  output logic      [15:0]            reg_rdata_o,
  output logic                        reg_rvalid_o,
  output logic      [15:0]            fault_status_o,
  output logic      [15:0]            fault_mask_o,
  output logic      [$clog2(ROM_WORDS)-1:0] rom_addr_o,
  output logic                        rom_check_done_o
);

  localparam int unsigned RAW = $clog2(ROM_WORDS);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  // The timer must reach CHECK_CYCLES - 1, and both registers must be valid addresses.
  if (MAP_WORDS < 1 || ROM_WORDS < 2 || CHECK_CYCLES < 2 ||
      CHECK_CYCLES >= (1 << TIMER_W) ||
      ADDR_LAST < ADDR_STATUS || ADDR_LAST < ADDR_MASK) begin : g_bad_param
    $error("ief_flags: parameter out of range");
  end

  typedef struct packed {
    logic [15:0]       status;
    logic [15:0]       mask;
    logic [15:0]       rdata;
    logic              rvalid;
    logic [15:0]       expect_sum;
    logic              recapture;
    logic [TIMER_W-1:0] timer;
    ief_rom_state_type rom_state;
    logic [RAW-1:0]    rom_addr;
    logic [15:0]       rom_acc;
    logic              rom_done;
  } ief_state_type;

  ief_state_type st;
  ief_state_type next_st;

  // ==========================================================================
  // Map checksum
  // ==========================================================================
  // A rotate-and-xor fold: cheap, and unlike a plain xor it sees swapped words.
  logic [15:0] map_sum;
  always_comb begin
    map_sum = 16'h0000;
    for (int i = 0; i < MAP_WORDS; i++) begin
      map_sum = {map_sum[14:0], map_sum[15]} ^ map_data_i[i*16 +: 16];
    end
  end

  logic        addr_ok;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic        check_tick;

  always_comb begin
    next_st    = st;
    addr_ok    = (reg_addr_i <= ADDR_LAST);
    set_bits   = 16'h0000;
    clr_bits   = 16'h0000;
    check_tick = 1'b0;

    // ========================================================================
    // Register access
    // ========================================================================
    // Read data is registered, so it answers one cycle after the strobe.
    next_st.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_STATUS) begin
        next_st.rdata = st.status & STATUS_IMPL;
      end else if (reg_addr_i == ADDR_MASK) begin
        next_st.rdata = st.mask;
      end else begin
        // Addresses with no storage in this block read zero.
        next_st.rdata = 16'h0000;
      end
    end
    if (reg_wr_i && addr_ok) begin
      if (reg_addr_i == ADDR_STATUS) begin
        clr_bits = reg_wdata_i;
      end else if (reg_addr_i == ADDR_MASK) begin
        next_st.mask = reg_wdata_i & MASK_WRITABLE;
      end
      // A host write legitimately changes the map, so relearn the sum next cycle.
      next_st.recapture = 1'b1;
    end

    if (reg_rd_i && !addr_ok) begin
      set_bits[BIT_BAD_READ] = 1'b1;
    end
    if (reg_wr_i && !addr_ok) begin
      set_bits[BIT_BAD_WRITE] = 1'b1;
    end
    if (link_sum_fail_i) begin
      set_bits[BIT_LINK_SUM] = 1'b1;
    end

    // ========================================================================
    // Periodic map check
    // ========================================================================
    // Relearning takes one cycle, so the sum is captured after the write has landed.
    if (st.recapture) begin
      next_st.expect_sum = map_sum;
      next_st.recapture  = reg_wr_i && addr_ok;
      next_st.timer      = '0;
    end else if (st.mask[BIT_MAP_SUM]) begin
      if (st.timer == TIMER_W'(CHECK_CYCLES - 1)) begin
        next_st.timer = '0;
        check_tick    = 1'b1;
      end else begin
        next_st.timer = st.timer + 1'b1;
      end
    end else begin
      next_st.timer = '0;
    end
    // A tick that meets a valid write is skipped; the sum is relearned next cycle anyway.
    // map mismatch
    if (check_tick && !(reg_wr_i && addr_ok) && map_sum != st.expect_sum) begin
      set_bits[BIT_MAP_SUM] = 1'b1;
    end

    // ========================================================================
    // ROM check after reset
    // ========================================================================
    case (st.rom_state)
      IEF_ROM_RUN: begin
        next_st.rom_acc = {st.rom_acc[14:0], st.rom_acc[15]} ^ rom_data_i;
        // The address stops on the last word rather than wrapping to word zero.
        if (st.rom_addr == RAW'(ROM_WORDS - 1)) begin
          next_st.rom_state = IEF_ROM_CHECK;
        end else begin
          next_st.rom_addr = st.rom_addr + 1'b1;
        end
      end
      IEF_ROM_CHECK: begin
        // The mask resets with this flag disabled; the host must enable it during the walk.
        if (st.rom_acc != ROM_SUM) begin
          set_bits[BIT_ROM_SUM] = 1'b1;
        end
        next_st.rom_state = IEF_ROM_DONE;
        next_st.rom_done  = 1'b1;
      end
      default: begin
        next_st.rom_state = IEF_ROM_DONE;
      end
    endcase

    // An event that meets its own clear wins, so no fault is lost.
    // set wins, gated by enable
    next_st.status = ((st.status & ~clr_bits) | (set_bits & st.mask)) & STATUS_IMPL;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.status     <= STATUS_RESET;
      st.mask       <= MASK_RESET;
      st.rdata      <= 16'h0000;
      st.rvalid     <= 1'b0;
      st.expect_sum <= 16'h0000;
      st.recapture  <= 1'b1;
      st.timer      <= '0;
      st.rom_state  <= IEF_ROM_RUN;
      st.rom_addr   <= '0;
      st.rom_acc    <= 16'h0000;
      st.rom_done   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata_o      = st.rdata;
  assign reg_rvalid_o     = st.rvalid;
  assign fault_status_o   = st.status;
  assign fault_mask_o     = st.mask;
  assign rom_addr_o       = st.rom_addr;
  assign rom_check_done_o = st.rom_done;

endmodule : ief_flags
`default_nettype wire

/* File: test/ief_rom_model.sv */
// Combinational ROM image that feeds the power-up checksum walk.
`timescale 1ns/1ps
`default_nettype none
module ief_rom_model #(
  parameter int unsigned AW = 3
) (
  input  wire logic [AW-1:0] addr_i,
  output logic      [15:0]   data_o
);
  // Each word differs, so a stuck address line changes the sum.
  assign data_o = 16'ha5a5 ^ 16'(addr_i);
endmodule : ief_rom_model
`default_nettype wire

/* File: test/ief_flags_props.sv */
// Port assertions for the integrity error flags.
`timescale 1ns/1ps
`default_nettype none
module ief_flags_props
  import ief_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [6:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        link_sum_fail_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [15:0] fault_status_o,
  input wire logic [15:0] fault_mask_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic bad   = reg_addr_i > ADDR_LAST_DEF;
  wire logic st_wr = reg_wr_i && reg_addr_i == ADDR_STATUS;
  // ====================
  // Flag setting
  property p_rd_err; reg_rd_i && bad && fault_mask_o[4] |=> fault_status_o[4]; endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read not flagged");
  property p_wr_err; reg_wr_i && bad && fault_mask_o[3] |=> fault_status_o[3]; endproperty
  a_wr_err: assert property (p_wr_err) else $error("bad write not flagged");
  property p_link; link_sum_fail_i && fault_mask_o[2] |=> fault_status_o[2]; endproperty
  a_link: assert property (p_link) else $error("link fail not flagged");
  property p_dis; (fault_status_o & ~$past(fault_status_o) & ~$past(fault_mask_o)) == 16'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled flag set");
  // ====================
  // Clearing and read back
  property p_hold; !st_wr |=> (fault_status_o & $past(fault_status_o)) == $past(fault_status_o);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_w1c; st_wr && !link_sum_fail_i && !reg_rd_i
    |=> (fault_status_o[4:2] & $past(reg_wdata_i[4:2])) == 3'h0; endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_rd_zero; reg_rd_i && bad |=> reg_rvalid_o && reg_rdata_o == 16'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("bad read data");
  property p_mask_rd; reg_rd_i && reg_addr_i == ADDR_MASK
    |=> reg_rvalid_o && reg_rdata_o == $past(fault_mask_o); endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
  cover property (reg_rd_i && bad);
  cover property (link_sum_fail_i && fault_mask_o[2]);
  cover property (st_wr);
  cover property (fault_status_o[0]);
  cover property (fault_status_o[1]);
endmodule : ief_flags_props
bind ief_flags ief_flags_props u_props (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .reg_wr_i        (reg_wr_i),
  .reg_rd_i        (reg_rd_i),
  .reg_addr_i      (reg_addr_i),
  .reg_wdata_i     (reg_wdata_i),
  .link_sum_fail_i (link_sum_fail_i),
  .reg_rdata_o     (reg_rdata_o),
  .reg_rvalid_o    (reg_rvalid_o),
  .fault_status_o  (fault_status_o),
  .fault_mask_o    (fault_mask_o)
);
`default_nettype wire

/* File: test/integrity_error_flags_test.sv */
// Self-checking bench for the integrity error flags.
`timescale 1ns/1ps
`default_nettype none
module integrity_error_flags_test;
  import ief_pkg::*;
  logic        clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, link_sum_fail_i = 0, rv;
  logic [6:0]  reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, rdata, rom_data, status, mask;
  logic [31:0] map = 32'h1234_5678;
  logic        rvalid, done;
  logic [2:0]  rom_addr;
  int          n_errors = 0, tests_run = 0;
  typedef struct {logic wr, rd, lk; logic [6:0] a; logic [15:0] d, st;} ief_row_type;
  ief_row_type rows[6] = '{'{0,0,1,7'h00,16'h0000,16'h0004}, '{0,1,0,7'h7f,16'h0000,16'h0014},
    '{1,0,0,7'h40,16'h0000,16'h001c}, '{1,0,0,7'h06,16'h0000,16'h001c},
    '{1,0,1,7'h06,16'h0004,16'h001c}, '{1,0,0,7'h06,16'h001c,16'h0000}};
  ief_flags #(.MAP_WORDS(2), .ROM_WORDS(8), .CHECK_CYCLES(4)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .link_sum_fail_i(link_sum_fail_i), .map_data_i(map),
    .rom_data_i(rom_data), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .fault_status_o(status), .fault_mask_o(mask), .rom_addr_o(rom_addr),
    .rom_check_done_o(done));
  ief_rom_model #(.AW(3)) u_rom (.addr_i(rom_addr), .data_o(rom_data));
  // ====================
  // Tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task drive(input logic wr, rd, lk, input logic [6:0] a, input logic [15:0] d);
    {reg_wr_i, reg_rd_i, link_sum_fail_i, reg_addr_i, reg_wdata_i} = {wr, rd, lk, a, d};
    @(negedge clk_i);
    rv = rvalid;
    {reg_wr_i, reg_rd_i, link_sum_fail_i} = 3'b000;
    @(negedge clk_i);
  endtask : drive
  task close_out;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ====================
  // Stimulus
  initial forever #4 clk_i = ~clk_i;
  // The whole run needs under 150 cycles, so this is ample.
  initial begin
    #20000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    check(mask, MASK_RESET);
    check(status, 16'h0000);
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk_i);
    check(16'(done), 16'h0001);
    check(status, 16'h0000);
    drive(1, 0, 0, ADDR_MASK, 16'h001f);
    foreach (rows[i]) begin
      drive(rows[i].wr, rows[i].rd, rows[i].lk, rows[i].a, rows[i].d);
      check(status, rows[i].st);
    end
    $display("table done");
    drive(0, 1, 0, ADDR_MASK, 16'h0000);
    check(16'(rv), 16'h0001);
    check(rdata, 16'h001f);
    map = 32'h1234_5679;
    for (int i = 0; i < 20 && status[1] !== 1'b1; i++) @(negedge clk_i);
    check(status, 16'h0002);
    drive(0, 1, 0, ADDR_STATUS, 16'h0000);
    check(rdata, 16'h0002);
    $display("map check done");
    drive(1, 0, 0, ADDR_MASK, 16'h0000);
    check(mask, 16'h0000);
    drive(1, 0, 0, ADDR_STATUS, 16'h001f);
    drive(0, 1, 1, 7'h7f, 16'h0000);
    check(status, 16'h0000);
    $display("mask off done");
    // Reset again mid-run and enable the ROM flag while the walk is still going.
    // The bench ROM image folds to 16'h000f, which differs from the default ROM_SUM of zero.
    rst_i = 1;
    @(negedge clk_i);
    rst_i = 0;
    check(mask, MASK_RESET);
    check(16'(rom_addr), 16'h0000);
    drive(1, 0, 0, ADDR_MASK, 16'h0001);
    check(16'(rom_addr), 16'h0002);
    check(16'(done), 16'h0000);
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk_i);
    check(status, 16'h0001);
    $display("rom flag done");
    close_out;
  end
endmodule : integrity_error_flags_test
`default_nettype wire
